// File: logic/tpw_pkg.sv
package tpw_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INIT = 8'h04;
	localparam logic [7:0] ADDR_PEND = 8'h08;
	localparam logic [7:0] ADDR_TRIG = 8'h0c;
	localparam logic [7:0] ADDR_DEAD = 8'h10;
	localparam logic [7:0] ADDR_RATIO = 8'h14;
	localparam logic [7:0] ADDR_DUTY0 = 8'h18;
	localparam logic [7:0] ADDR_DUTY1 = 8'h1c;
	localparam logic [7:0] ADDR_DUTY2 = 8'h20;
	localparam logic [7:0] ADDR_DAC = 8'h24;
	localparam logic [7:0] ADDR_STAT = 8'h28;
	localparam logic [7:0] ADDR_MASK = 8'h2c;
	localparam logic [7:0] ADDR_STATE = 8'h30;
	localparam logic [7:0] ADDR_RES0 = 8'h34;
	localparam logic [7:0] ADDR_RES1 = 8'h38;

	// control bits
	localparam int CTRL_RUN = 0;
	localparam int CTRL_AUTO = 1;
	localparam int CTRL_SYNC = 2;
	localparam int CTRL_W = 3;

	// status bits, same layout for the mask
	localparam int ST_CONV = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_RELOAD = 2;
	localparam int ST_W = 3;

	// widths fixed by the application
	localparam int CNT_W = 16;
	localparam int DT_W = 12;
	localparam int RATIO_W = 8;
	localparam int DAC_W = 6;
	localparam int RES_W = 10;
	localparam int PHASES = 3;
	localparam int CONVS = 2;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h6;
	localparam logic [CNT_W-1:0] INIT_RST = 16'he2b4;
	localparam logic [CNT_W-1:0] PEND_RST = 16'h1d4b;
	localparam logic [CNT_W-1:0] TRIG_RST = 16'he2e6;
	localparam logic [DT_W-1:0] DEAD_RST = 12'h064;
	localparam logic [RATIO_W-1:0] RATIO_RST = 8'h01;
	localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
	localparam logic [DAC_W-1:0] DAC_RST = 6'h3e;

	// comparator filter length in matching samples
	localparam logic [2:0] FILT_SAMPLES = 3'h4;

	// conversion chain, gray coded along the scan order
	typedef enum logic [1:0]
	{
		TPW_CH_IDLE = 2'b00,
		TPW_CH_SCAN1 = 2'b01,
		TPW_CH_SCAN2 = 2'b11
	} tpw_chain_t;
endpackage

// File: logic/tpw_top.sv
`timescale 1ns/1ps
// Overview of operation
// - six outputs, three phase pairs from master and two follower counters; fourth unused
// - master raises global reload once every N period wraps, N programmable
// - follower counters advance on the master's count tick, no own prescaler
// - follower counters are forced to the initial value by master reload
// - after each reload master pulses trigger when counter equals trigger compare
// - trigger compare default sits half a dead time after counter start
// - pwm rate is integer multiple of conversion interrupt rate; ratio one equal
// - period runs initial value to period end; defaults -7500 and 7499
// - counters run on the peripheral clock root
// - programmable dead time inserted between top and bottom of each pair
// - fault disables all outputs; auto clear re-enables at reload after fault low
// - comparator checks sensed current against a 6-bit reference code
// - comparator filter flips only after four consecutive differing samples
// - each converter runs a two-scan chain, second starting when first ends
// - shared trigger mode launches both chains from the master trigger together
// - converters clocked at half the peripheral clock, 10-bit hardware triggered
// - conversion interrupt raised when first converter ends its last scan
// - master trigger routed out to the first converter-controller trigger input
module tpw_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [2:0] pwm_top,
	output logic [2:0] pwm_bot,
	output logic trig_out,
	output logic conv_clk,
	output logic [1:0] conv_start,
	output logic [1:0] conv_scan,
	input wire logic [1:0] conv_done,
	input wire logic [9:0] conv_data0,
	input wire logic [9:0] conv_data1,
	input wire logic [5:0] current_level,
	output logic irq
);
	localparam int CW = tpw_pkg::CNT_W;

	logic hreadyout_q;
	logic hresp_q;
	logic [31:0] hrdata_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [tpw_pkg::CTRL_W-1:0] ctrl_q;
	logic signed [CW-1:0] init_q;
	logic signed [CW-1:0] pend_q;
	logic signed [CW-1:0] trig_q;
	logic [tpw_pkg::DT_W-1:0] dead_q;
	logic [tpw_pkg::RATIO_W-1:0] ratio_q;
	logic signed [CW-1:0] duty_q [tpw_pkg::PHASES];
	logic [tpw_pkg::DAC_W-1:0] dac_q;
	logic [tpw_pkg::ST_W-1:0] stat_q;
	logic [tpw_pkg::ST_W-1:0] mask_q;
	logic irq_q;
	logic signed [CW-1:0] cnt_q [tpw_pkg::PHASES];
	logic [tpw_pkg::RATIO_W-1:0] opp_q;
	logic armed_q;
	logic trig_q_out;
	logic filt_q;
	logic [2:0] filt_cnt_q;
	logic dis_q;
	logic conv_clk_q;
	logic [2:0] top_q;
	logic [2:0] bot_q;
	logic [1:0] start_q;
	logic [1:0] enter_q;
	logic [1:0] scan_q;
	logic [tpw_pkg::RES_W-1:0] res_q [tpw_pkg::CONVS][2];
	logic [tpw_pkg::ST_W-1:0] ev;
	logic [1:0] conv_last;

	// ahb address phase decode
	wire addr_ok = hsel & htrans[1] & hready;
	wire wr_ctrl = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_CTRL);
	wire wr_init = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_INIT);
	wire wr_pend = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_PEND);
	wire wr_trig = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_TRIG);
	wire wr_dead = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_DEAD);
	wire wr_ratio = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_RATIO);
	wire wr_dac = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_DAC);
	wire wr_stat = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_STAT);
	wire wr_mask = wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_MASK);
	wire [2:0] wr_duty = {wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_DUTY2),
		wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_DUTY1),
		wr_pend_q & (wr_addr_q == tpw_pkg::ADDR_DUTY0)};
	wire run = ctrl_q[tpw_pkg::CTRL_RUN];
	wire auto_clr = ctrl_q[tpw_pkg::CTRL_AUTO];
	wire shared_trigger_mode = ctrl_q[tpw_pkg::CTRL_SYNC];
	wire [7:0] ra = haddr[7:0];

	// read data selection, unmapped offsets read zero
	wire [31:0] state_word = {26'h0000000, scan_q, conv_clk_q, armed_q, dis_q, filt_q};
	wire [31:0] res0_word = {6'h00, res_q[0][1], 6'h00, res_q[0][0]};
	wire [31:0] res1_word = {6'h00, res_q[1][1], 6'h00, res_q[1][0]};
	wire [31:0] rd_mux =
		(ra == tpw_pkg::ADDR_CTRL) ? {29'h00000000, ctrl_q} :
		(ra == tpw_pkg::ADDR_INIT) ? {16'h0000, init_q} :
		(ra == tpw_pkg::ADDR_PEND) ? {16'h0000, pend_q} :
		(ra == tpw_pkg::ADDR_TRIG) ? {16'h0000, trig_q} :
		(ra == tpw_pkg::ADDR_DEAD) ? {20'h00000, dead_q} :
		(ra == tpw_pkg::ADDR_RATIO) ? {24'h000000, ratio_q} :
		(ra == tpw_pkg::ADDR_DUTY0) ? {16'h0000, duty_q[0]} :
		(ra == tpw_pkg::ADDR_DUTY1) ? {16'h0000, duty_q[1]} :
		(ra == tpw_pkg::ADDR_DUTY2) ? {16'h0000, duty_q[2]} :
		(ra == tpw_pkg::ADDR_DAC) ? {26'h0000000, dac_q} :
		(ra == tpw_pkg::ADDR_STAT) ? {29'h00000000, stat_q} :
		(ra == tpw_pkg::ADDR_MASK) ? {29'h00000000, mask_q} :
		(ra == tpw_pkg::ADDR_STATE) ? state_word :
		(ra == tpw_pkg::ADDR_RES0) ? res0_word :
		(ra == tpw_pkg::ADDR_RES1) ? res1_word : 32'h00000000;

	// bus slave: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= addr_ok & hwrite;
			wr_addr_q <= haddr[7:0];
			hrdata_q <= (addr_ok & ~hwrite) ? rd_mux : 32'h00000000;
		end
	end

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q <= tpw_pkg::CTRL_RST;
			init_q <= tpw_pkg::INIT_RST;
			pend_q <= tpw_pkg::PEND_RST;
			trig_q <= tpw_pkg::TRIG_RST;
			dead_q <= tpw_pkg::DEAD_RST;
			ratio_q <= tpw_pkg::RATIO_RST;
			dac_q <= tpw_pkg::DAC_RST;
			mask_q <= '0;
		end
		else
		begin
			if (wr_ctrl) ctrl_q <= hwdata[tpw_pkg::CTRL_W-1:0];
			if (wr_init) init_q <= hwdata[CW-1:0];
			if (wr_pend) pend_q <= hwdata[CW-1:0];
			if (wr_trig) trig_q <= hwdata[CW-1:0];
			if (wr_dead) dead_q <= hwdata[tpw_pkg::DT_W-1:0];
			if (wr_ratio) ratio_q <= hwdata[tpw_pkg::RATIO_W-1:0];
			if (wr_dac) dac_q <= hwdata[tpw_pkg::DAC_W-1:0];
			if (wr_mask) mask_q <= hwdata[tpw_pkg::ST_W-1:0];
		end
	end

	// sticky status, a new event beats a write-one clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~(wr_stat ? hwdata[tpw_pkg::ST_W-1:0] : 3'h0)) | ev;
			irq_q <= |(stat_q & mask_q);
		end
	end

	// master wrap is a reload opportunity; every n-th one is the global reload
	wire [tpw_pkg::RATIO_W-1:0] ratio_eff = (ratio_q == 8'h00) ? 8'h01 : ratio_q;
	wire wrap = run & (cnt_q[0] >= pend_q);
	wire [tpw_pkg::RATIO_W-1:0] opp_next = opp_q + 8'h01;
	wire reload = wrap & (opp_next >= ratio_eff);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			opp_q <= '0;
		else if (!run || reload)
			opp_q <= '0;
		else if (wrap)
			opp_q <= opp_next;
	end

	// phase counters, compare and dead time per pair
	genvar p;
	generate
		for (p = 0; p < tpw_pkg::PHASES; p++)
		begin : g_phase
			logic signed [CW-1:0] duty_act_q;
			logic ideal_q;
			logic [tpw_pkg::DT_W-1:0] dtc_q;
			wire signed [CW-1:0] neg_duty = CW'(-duty_act_q);
			wire ideal = run & (cnt_q[p] >= neg_duty) & (cnt_q[p] < duty_act_q);
			wire settled = (dtc_q >= dead_q);
			// all counters advance on the master tick; reload realigns followers
			wire restart = (p == 0) ? wrap : (reload | (cnt_q[p] >= pend_q));

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					cnt_q[p] <= tpw_pkg::INIT_RST;
					duty_q[p] <= tpw_pkg::DUTY_RST;
					duty_act_q <= tpw_pkg::DUTY_RST;
					ideal_q <= 1'b0;
					dtc_q <= '0;
					top_q[p] <= 1'b0;
					bot_q[p] <= 1'b0;
				end
				else
				begin
					if (!run || restart)
						cnt_q[p] <= init_q;
					else
						cnt_q[p] <= cnt_q[p] + 16'sh0001;
					if (wr_duty[p]) duty_q[p] <= hwdata[CW-1:0];
					if (reload || !run) duty_act_q <= duty_q[p];
					ideal_q <= ideal;
					if (ideal != ideal_q)
						dtc_q <= '0;
					else if (!settled)
						dtc_q <= dtc_q + 12'h001;
					top_q[p] <= ideal_q & settled & ~dis_q;
					bot_q[p] <= run & ~ideal_q & settled & ~dis_q;
				end
			end
		end
	endgenerate

	// trigger armed by reload, fired once at the compare match
	wire fire = armed_q & run & (cnt_q[0] == trig_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			armed_q <= 1'b0;
			trig_q_out <= 1'b0;
		end
		else
		begin
			armed_q <= run & (reload | (armed_q & ~fire));
			trig_q_out <= fire;
		end
	end

	// comparator with four-sample agreement filter
	wire raw_cmp = (current_level > dac_q);
	wire filt_flip = (raw_cmp != filt_q) & (filt_cnt_q == (tpw_pkg::FILT_SAMPLES - 3'h1));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			filt_q <= 1'b0;
			filt_cnt_q <= 3'h0;
		end
		else if (raw_cmp == filt_q || filt_flip)
		begin
			filt_cnt_q <= 3'h0;
			filt_q <= filt_flip ? raw_cmp : filt_q;
		end
		else
			filt_cnt_q <= filt_cnt_q + 3'h1;
	end

	// fault latch; manual mode needs the fault status cleared first
	wire fault = filt_q;
	wire clr_ok = auto_clr | ~stat_q[tpw_pkg::ST_FAULT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dis_q <= 1'b0;
		else if (fault)
			dis_q <= 1'b1;
		else if (reload && clr_ok)
			dis_q <= 1'b0;
	end

	// converter clock is half the peripheral clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			conv_clk_q <= 1'b0;
		else
			conv_clk_q <= ~conv_clk_q;
	end

	// one two-scan chain per converter
	genvar c;
	generate
		for (c = 0; c < tpw_pkg::CONVS; c++)
		begin : g_chain
			tpw_pkg::tpw_chain_t st_q;
			tpw_pkg::tpw_chain_t st_d;
			wire launch = trig_q_out & ((c == 0) | shared_trigger_mode);
			wire [9:0] data = (c == 0) ? conv_data0 : conv_data1;
			logic enter;

			always_comb
			begin
				st_d = st_q;
				enter = 1'b0;
				case (st_q)
					tpw_pkg::TPW_CH_IDLE:
					begin
						if (launch)
						begin
							st_d = tpw_pkg::TPW_CH_SCAN1;
							enter = 1'b1;
						end
					end
					tpw_pkg::TPW_CH_SCAN1:
					begin
						if (conv_done[c])
						begin
							st_d = tpw_pkg::TPW_CH_SCAN2;
							enter = 1'b1;
						end
					end
					tpw_pkg::TPW_CH_SCAN2:
					begin
						if (conv_done[c])
							st_d = tpw_pkg::TPW_CH_IDLE;
					end
					default:
						st_d = tpw_pkg::TPW_CH_IDLE;
				endcase
			end

			assign conv_last[c] = (st_q == tpw_pkg::TPW_CH_SCAN2) & conv_done[c];

			// start strobe spans one converter clock period
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					st_q <= tpw_pkg::TPW_CH_IDLE;
					enter_q[c] <= 1'b0;
					start_q[c] <= 1'b0;
					scan_q[c] <= 1'b0;
					res_q[c][0] <= '0;
					res_q[c][1] <= '0;
				end
				else
				begin
					st_q <= st_d;
					enter_q[c] <= enter;
					start_q[c] <= enter | enter_q[c];
					scan_q[c] <= (st_d == tpw_pkg::TPW_CH_SCAN2);
					if (conv_done[c] && st_q == tpw_pkg::TPW_CH_SCAN1) res_q[c][0] <= data;
					if (conv_last[c]) res_q[c][1] <= data;
				end
			end
		end
	endgenerate

	// events feeding the status register
	assign ev[tpw_pkg::ST_CONV] = conv_last[0];
	assign ev[tpw_pkg::ST_FAULT] = fault;
	assign ev[tpw_pkg::ST_RELOAD] = reload;

	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign pwm_top = top_q;
	assign pwm_bot = bot_q;
	assign trig_out = trig_q_out;
	assign conv_clk = conv_clk_q;
	assign conv_start = start_q;
	assign conv_scan = scan_q;
	assign irq = irq_q;
endmodule

// File: logic/tpw_end.sv
`timescale 1ns/1ps

// File: tb/tpw_conv_model.sv
`timescale 1ns/1ps
// behavioural pair of converters: each start rise is answered after lat cycles
module tpw_conv_model
#(
	parameter int LAT = 5
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] start,
	input wire logic [1:0] scan,
	output logic [1:0] done,
	output logic [9:0] data0,
	output logic [9:0] data1
);
	logic [1:0] prev;
	int cnt [2];
	// data stand only in the done cycle and are inverted every cycle otherwise
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			prev <= 2'h0;
			done <= 2'h0;
			data0 <= 10'h000;
			data1 <= 10'h000;
			cnt <= '{0, 0};
		end
		else
		begin
			prev <= start;
			for (int c = 0; c < 2; c++)
			begin
				done[c] <= (cnt[c] == 1);
				if (start[c] && !prev[c])
					cnt[c] <= LAT;
				else if (cnt[c] > 0)
					cnt[c] <= cnt[c] - 1;
			end
			data0 <= (cnt[0] == 1) ? {1'b0, scan[0], 8'h3c} : ~data0;
			data1 <= (cnt[1] == 1) ? {1'b1, scan[1], 8'h3c} : ~data1;
		end
endmodule

// File: tb/tpw_top_properties.sv
`timescale 1ns/1ps
module tpw_properties
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [2:0] pwm_top,
	input wire logic [2:0] pwm_bot,
	input wire logic trig_out,
	input wire logic conv_clk,
	input wire logic [1:0] conv_start,
	input wire logic [1:0] conv_scan,
	input wire logic irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// an accepted read address phase
	wire logic rd_acc = hsel && htrans[1] && hready && !hwrite;
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_rdata_idle: assert property (!rd_acc |=> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	a_trig_pulse: assert property (trig_out |=> !trig_out)
		else $error("trigger longer than one cycle");
	a_trig_launch: assert property (trig_out |-> ##2 conv_start[0])
		else $error("trigger did not launch the first chain");
	a_start_len: assert property ($rose(conv_start[0]) |-> conv_start[0][*2] ##1 !conv_start[0])
		else $error("start strobe not two cycles");
	a_scan_next: assert property ($rose(conv_scan[0]) |-> $rose(conv_start[0]))
		else $error("second scan not started");
	a_shared_launch: assert property ($rose(conv_start[1]) && !conv_scan[1] |-> $rose(conv_start[0]))
		else $error("chains not launched together");
	a_dead_gap: assert property ((pwm_top & pwm_bot) == 3'h0)
		else $error("top and bottom on together");
	a_conv_clk_half: assert property ($past(hresetn) |-> conv_clk != $past(conv_clk))
		else $error("converter clock not half rate");
	c_irq: cover property (irq);
	c_shared: cover property ($rose(conv_start[1]));
	c_trig: cover property (trig_out);
endmodule
bind tpw_top tpw_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .pwm_top(pwm_top), .pwm_bot(pwm_bot), .trig_out(trig_out),
	.conv_clk(conv_clk), .conv_start(conv_start), .conv_scan(conv_scan), .irq(irq));

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [5:0] current_level;
	wire logic hreadyout, hresp, trig_out, conv_clk, irq;
	wire logic [31:0] hrdata;
	wire logic [2:0] pwm_top, pwm_bot;
	wire logic [1:0] conv_start, conv_scan, conv_done;
	wire logic [9:0] conv_data0, conv_data1;
	int fails, tests_run, n, h;
	logic s, m;
	// reset rows: offset and expected word; 3c is unmapped
	logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h3c};
	logic [31:0] rv [8] = '{32'h6, 32'he2b4, 32'h1d4b, 32'he2e6, 32'h64, 32'h1, 32'h3e, 32'h0};
	// run set-up rows: period of 40 cycles, dead time 4, equal duties
	logic [7:0] wa [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h2c, 8'h00};
	logic [31:0] wv [9] = '{32'hffec, 32'h13, 32'hfff1, 32'h4, 32'ha, 32'ha, 32'ha, 32'h7, 32'h7};
	tpw_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_top(pwm_top),
		.pwm_bot(pwm_bot), .trig_out(trig_out), .conv_clk(conv_clk), .conv_start(conv_start),
		.conv_scan(conv_scan), .conv_done(conv_done), .conv_data0(conv_data0),
		.conv_data1(conv_data1), .current_level(current_level), .irq(irq));
	tpw_conv_model #(.LAT(5)) model (.hclk(hclk), .hresetn(hresetn), .start(conv_start),
		.scan(conv_scan), .done(conv_done), .data0(conv_data0), .data1(conv_data1));
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// cuts a hang short
	initial
	begin
		#100000;
		fails++;
		end_sim;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single transfer; ready and read data are sampled at the rising edge
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rdm(input string nm, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(nm, rd & msk, e);
	endtask
	task wait_trig();
		n = 0;
		do
		begin
			@(negedge hclk);
			n++;
		end while (trig_out !== 1'b1 && n < 1000);
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		current_level = 6'h00;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rdm("reset value", ra[i], 32'hffffffff, rv[i]);
		for (int i = 0; i < 9; i++)
			bus(wa[i], 1'b1, wv[i]);
		wait_trig();
		wait_trig();
		chk("trigger interval", n, 40);
		bus(tpw_pkg::ADDR_RATIO, 1'b1, 32'h2);
		repeat (3) wait_trig();
		chk("trigger interval ratio", n, 80);
		repeat (30) @(negedge hclk);
		rdm("status", tpw_pkg::ADDR_STAT, 32'hffffffff, 32'h5);
		rdm("results first", tpw_pkg::ADDR_RES0, 32'hffffffff, 32'h013c003c);
		rdm("results second", tpw_pkg::ADDR_RES1, 32'hffffffff, 32'h033c023c);
		chk("irq set", irq, 1'b1);
		bus(tpw_pkg::ADDR_MASK, 1'b1, 32'h0);
		// the mask lands at the end of the data phase, the interrupt one edge later
		repeat (2) @(negedge hclk);
		chk("irq masked", irq, 1'b0);
		bus(tpw_pkg::ADDR_CTRL, 1'b1, 32'h6);
		bus(tpw_pkg::ADDR_STAT, 1'b1, 32'h7);
		rdm("status cleared", tpw_pkg::ADDR_STAT, 32'hffffffff, 32'h0);
		chk("stopped outputs", {pwm_top, pwm_bot}, 6'h0);
		bus(tpw_pkg::ADDR_CTRL, 1'b1, 32'h3);
		wait_trig();
		s = 1'b0;
		m = 1'b0;
		h = 0;
		repeat (80)
		begin
			@(negedge hclk);
			s = s | conv_start[1];
			m = m | (pwm_top != {3{pwm_top[0]}});
			h = h + pwm_top[0];
		end
		chk("single chain", s, 1'b0);
		chk("phases aligned", m, 1'b0);
		chk("top active", h > 0 && h < 40, 1'b1);
		bus(tpw_pkg::ADDR_CTRL, 1'b1, 32'h7);
		@(posedge hclk);
		current_level <= 6'h3f;
		repeat (3) @(posedge hclk);
		current_level <= 6'h00;
		rdm("short glitch", tpw_pkg::ADDR_STAT, 32'h2, 32'h0);
		@(posedge hclk);
		current_level <= 6'h3f;
		repeat (8) @(posedge hclk);
		@(negedge hclk);
		chk("fault outputs", {pwm_top, pwm_bot}, 6'h0);
		rdm("fault state", tpw_pkg::ADDR_STATE, 32'h3, 32'h3);
		@(posedge hclk);
		current_level <= 6'h00;
		n = 0;
		do
		begin
			@(negedge hclk);
			n++;
		end while (pwm_top === 3'h0 && n < 200);
		chk("auto recovery", n < 200, 1'b1);
		// manual clearing: outputs stay off until the fault status is cleared
		bus(tpw_pkg::ADDR_CTRL, 1'b1, 32'h5);
		@(posedge hclk);
		current_level <= 6'h3f;
		repeat (8) @(posedge hclk);
		current_level <= 6'h00;
		repeat (200) @(negedge hclk);
		chk("manual hold", pwm_top, 3'h0);
		bus(tpw_pkg::ADDR_STAT, 1'b1, 32'h2);
		n = 0;
		do
		begin
			@(negedge hclk);
			n++;
		end while (pwm_top === 3'h0 && n < 200);
		chk("manual recovery", n < 200, 1'b1);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(negedge hclk);
		chk("reset outputs", {pwm_top, pwm_bot, trig_out, irq, conv_start, conv_clk, hresp, hreadyout}, 13'h001);
		@(posedge hclk);
		hresetn <= 1'b1;
		rdm("reset ctrl", tpw_pkg::ADDR_CTRL, 32'hffffffff, 32'h6);
		end_sim;
	end
endmodule
